// *** pop_out_mem.sv ***
// Memory model standing on the far side of the block's memory request port.
// Assumes the block holds mem.req until memAck; slow adds wait states to every cycle.
`timescale 1ns/1ns
module pop_out_mem
	import pop_out_pkg::*;
(
	input  logic        mclk,
	input  logic        rstn,
	input  mem_req_t    mem,
	input  logic        slow,
	output logic [15:0] memRdata,
	output logic        memAck
);
	logic [7:0] memB [logic [19:0]]; // Byte store, preloaded by the bench.
	logic [2:0] waitCnt_ff;          // Wait states spent on the pending cycle.

	// Answer one cycle at a time; outside an answer the read bus flips every cycle,
	// so a block that samples stale read data cannot pass by luck.
	always @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			memAck     <= 1'b0;
			waitCnt_ff <= 3'h0;
			memRdata   <= 16'h0000;
		end
		else if (mem.req && !memAck && waitCnt_ff >= (slow ? 3'h3 : 3'h0))
		begin
			memAck     <= 1'b1;
			waitCnt_ff <= 3'h0;
			if (mem.we)
			begin
				memB[mem.addr] = mem.wdata[7:0];
				if (!mem.isByte)
					memB[mem.addr + 20'h1] = mem.wdata[15:8];
			end
			else if (mem.isByte)
				memRdata <= {~memB[mem.addr], memB[mem.addr]};
			else
				memRdata <= {memB[mem.addr + 20'h1], memB[mem.addr]};
		end
		else
		begin
			memAck     <= 1'b0;
			memRdata   <= ~memRdata;
			waitCnt_ff <= (mem.req && !memAck) ? waitCnt_ff + 3'h1 : 3'h0;
		end
	end
endmodule : pop_out_mem

// *** pop_out_pkg.sv ***
// Constants, register map and carrier types for the port output and stack pop execution block.
// Assumes one 25 MHz clock and an APB master holding the register bus.
package pop_out_pkg;
	// Register byte offsets on the APB bus.
	localparam logic [7:0] OFF_CTRL   = 8'h00;
	localparam logic [7:0] OFF_INSTR  = 8'h04;
	localparam logic [7:0] OFF_STATUS = 8'h08;
	localparam logic [7:0] OFF_FLAGS  = 8'h0c;
	localparam logic [7:0] OFF_DISP   = 8'h10;
	localparam logic [7:0] OFF_SEG    = 8'h20;
	localparam logic [7:0] OFF_GPR    = 8'h40;
	// Control and status bit positions.
	localparam int CTRL_START   = 0;
	localparam int CTRL_VARIANT = 1;
	localparam int CTRL_REP     = 2;
	localparam int CTRL_PCB_MEM = 3;
	localparam int ST_DONE      = 1;
	localparam int DF_BIT       = 10;
	localparam int INSTR_SPBASE = 24;
	// Register file indices.
	localparam int GPR_AX = 0;
	localparam int GPR_CX = 1;
	localparam int GPR_DX = 2;
	localparam int GPR_SP = 4;
	localparam int GPR_SI = 6;
	localparam int SEG_ES = 0;
	localparam int SEG_SS = 2;
	localparam int SEG_DS = 3;
	// Opcodes handled here.
	localparam logic [7:0] OP_OUT_IB = 8'he6;
	localparam logic [7:0] OP_OUT_IW = 8'he7;
	localparam logic [7:0] OP_OUT_DB = 8'hee;
	localparam logic [7:0] OP_OUT_DW = 8'hef;
	localparam logic [7:0] OP_STR_B  = 8'h6e;
	localparam logic [7:0] OP_STR_W  = 8'h6f;
	localparam logic [7:0] OP_POP_M  = 8'h8f;
	localparam logic [4:0] OP_POP_R  = 5'h0b;
	localparam logic [7:0] OP_POP_DS = 8'h1f;
	localparam logic [7:0] OP_POP_ES = 8'h07;
	localparam logic [7:0] OP_POP_SS = 8'h17;
	// Instruction lengths in clocks; the suffix 2 marks the byte-bus variant.
	localparam logic [5:0] CLK_OUT_I   = 6'h09;
	localparam logic [5:0] CLK_OUT_IW2 = 6'h0d;
	localparam logic [5:0] CLK_OUT_D   = 6'h07;
	localparam logic [5:0] CLK_OUT_DW2 = 6'h0b;
	localparam logic [5:0] CLK_STR     = 6'h0e;
	localparam logic [5:0] CLK_POP_M   = 6'h14;
	localparam logic [5:0] CLK_POP_M2  = 6'h18;
	localparam logic [5:0] CLK_POP_R   = 6'h0a;
	localparam logic [5:0] CLK_POP_R2  = 6'h0e;
	localparam logic [5:0] CLK_POP_S   = 6'h08;
	localparam logic [5:0] CLK_POP_S2  = 6'h0c;
	localparam logic [5:0] CLK_MIN     = 6'h01;
	// Pointer steps and reset values.
	localparam logic [15:0] STACK_STEP = 16'h0002;
	localparam logic [15:0] STEP_BYTE  = 16'h0001;
	localparam logic [15:0] STEP_WORD  = 16'h0002;
	localparam logic        PCB_IO_RST = 1'b1;
	// Sequencer states.
	typedef enum logic [4:0] {S_IDLE = 5'b00001, S_READ = 5'b00010, S_STORE = 5'b00100,
		S_WRITE = 5'b01000, S_WAIT = 5'b10000} state_t;
	// I/O space write cycle.
	typedef struct packed {logic req; logic isByte; logic [15:0] addr; logic [15:0] data;} io_wr_t;
	// Memory cycle request.
	typedef struct packed {logic req; logic we; logic isByte; logic [19:0] addr; logic [15:0] wdata;} mem_req_t;
	// Whole state of the block.
	typedef struct packed {
		state_t st; logic [5:0] cnt; logic half; logic [15:0] data; logic [15:0] addrOff;
		logic variant; logic repeat_prefix; logic pcbIo; logic busy; logic done; logic illegal;
		logic inhibit; logic popSs; logic [7:0] opcode; logic [7:0] modrm; logic [7:0] imm;
		logic spBase; logic [15:0] disp; logic [15:0] flags;
		logic [3:0][15:0] seg; logic [7:0][15:0] gpr;
		io_wr_t io; mem_req_t mem; logic pready; logic pslverr; logic [31:0] prdata;
	} core_t;
endpackage : pop_out_pkg

// *** port_output_and_stack_pop_exec.sv ***
// Execution sequencer for port output, string output and stack pop instructions.
// Assumes an APB master, memory that answers with memAck on this clock, and writes to I/O space that always land.
//
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/1ns
module port_output_and_stack_pop_exec
	import pop_out_pkg::*;
(
	input  logic        mclk,
	input  logic        rstn,
	input  logic        psel,
	input  logic        penable,
	input  logic        pwrite,
	input  logic [7:0]  paddr,
	input  logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic        pready,
	output logic        pslverr,
	output io_wr_t      io,
	output mem_req_t    mem,
	input  logic [15:0] memRdata,
	input  logic        memAck,
	output logic        intBlock,
	output logic        pcbInIoSpace
);
	core_t       r;       // Registered state.
	core_t       n;       // Next state.
	logic        wr;      // APB write takes effect this edge.
	logic        launch;  // A start command is accepted this edge.
	logic        fin;     // The running instruction completes this edge.
	logic        word;    // The current instruction moves a word.
	logic        split;   // The word travels as two byte cycles.
	logic        strOp;   // The current instruction is string output.
	logic [15:0] capt;    // Read data merged with earlier bytes.
	logic [15:0] newSp;   // Stack pointer after the pop step.

	// Physical address from a segment and an offset.
	function automatic logic [19:0] phys(input logic [15:0] sg, input logic [15:0] off);
		phys = {sg, 4'h0} + {4'h0, off};
	endfunction : phys

	// True for every pop form this block executes.
	function automatic logic isPop(input logic [7:0] op, input logic [7:0] mr);
		isPop = (op[7:3] == OP_POP_R) || (op == OP_POP_DS) || (op == OP_POP_ES) ||
			(op == OP_POP_SS) || ((op == OP_POP_M) && (mr[5:3] == 3'h0));
	endfunction : isPop

	// Source index after one element.
	function automatic logic [15:0] siStep(input logic [15:0] si, input logic wd, input logic df);
		siStep = df ? si - (wd ? STEP_WORD : STEP_BYTE) : si + (wd ? STEP_WORD : STEP_BYTE);
	endfunction : siStep

	// Instruction length in clocks for each form and variant.
	function automatic logic [5:0] clocksFor(input logic [7:0] op, input logic v);
		if (op == OP_OUT_IB)
			clocksFor = CLK_OUT_I;
		else if (op == OP_OUT_IW)
			clocksFor = v ? CLK_OUT_IW2 : CLK_OUT_I;
		else if (op == OP_OUT_DB)
			clocksFor = CLK_OUT_D;
		else if (op == OP_OUT_DW)
			clocksFor = v ? CLK_OUT_DW2 : CLK_OUT_D;
		else if ((op == OP_STR_B) || (op == OP_STR_W))
			clocksFor = CLK_STR;
		else if (op == OP_POP_M)
			clocksFor = v ? CLK_POP_M2 : CLK_POP_M;
		else if (op[7:3] == OP_POP_R)
			clocksFor = v ? CLK_POP_R2 : CLK_POP_R;
		else
			clocksFor = v ? CLK_POP_S2 : CLK_POP_S;
	endfunction : clocksFor

	// The write lands on the edge where the master sees pready high.
	assign wr = psel && penable && r.pready && pwrite;
	// A start is only honoured while idle; a start while busy is dropped.
	assign launch = wr && (paddr == OFF_CTRL) && pwdata[CTRL_START] && !r.busy;

	// All outputs come straight from state flops.
	assign prdata = r.prdata;
	assign pready = r.pready;
	assign pslverr = r.pslverr;
	assign io = r.io;
	assign mem = r.mem;
	assign intBlock = r.inhibit;
	assign pcbInIoSpace = r.pcbIo;

	// Next state: bus slave, register writes, launch decode and sequencer.
	always_comb
	begin
		n = r;
		fin = 1'b0;
		capt = r.data;
		newSp = r.gpr[GPR_SP] + STACK_STEP;
		word = isPop(r.opcode, r.modrm) || r.opcode[0];
		split = word && r.variant;
		strOp = (r.opcode == OP_STR_B) || (r.opcode == OP_STR_W);
		n.io.req = 1'b0;
		n.pready = 1'b0;
		n.pslverr = 1'b0;
		// The instruction counter runs freely down to zero.
		if (r.cnt != 6'h00)
			n.cnt = r.cnt - CLK_MIN;
		// Access phase: one wait state, then data and pready together.
		if (psel && penable && !r.pready)
		begin
			n.pready = 1'b1;
			n.prdata = 32'h0;
			if (paddr[1:0] != 2'h0)
				n.pslverr = 1'b1;
			else if (paddr == OFF_CTRL)
				n.prdata = {28'h0, !r.pcbIo, r.repeat_prefix, r.variant, 1'b0};
			else if (paddr == OFF_INSTR)
				n.prdata = {7'h0, r.spBase, r.imm, r.modrm, r.opcode};
			else if (paddr == OFF_STATUS)
				n.prdata = {28'h0, r.inhibit, r.illegal, r.done, r.busy};
			else if (paddr == OFF_FLAGS)
				n.prdata = {16'h0, r.flags};
			else if (paddr == OFF_DISP)
				n.prdata = {16'h0, r.disp};
			else if ((paddr[7:5] == OFF_SEG[7:5]) && !paddr[4])
				n.prdata = {16'h0, r.seg[paddr[3:2]]};
			else if (paddr[7:5] == OFF_GPR[7:5])
				n.prdata = {16'h0, r.gpr[paddr[4:2]]};
			else
				n.pslverr = 1'b1;
		end
		// Software clears the done flag; a completion in the same edge still sets it below.
		if (wr && (paddr == OFF_STATUS) && pwdata[ST_DONE])
			n.done = 1'b0;
		// Register writes other than the done clear are ignored while an instruction runs, so software cannot race the sequencer.
		if (wr && !r.busy)
		begin
			if (paddr == OFF_CTRL)
			begin
				n.variant = pwdata[CTRL_VARIANT];
				n.repeat_prefix = pwdata[CTRL_REP];
				n.pcbIo = !pwdata[CTRL_PCB_MEM];
			end
			else if (paddr == OFF_INSTR)
			begin
				n.opcode = pwdata[7:0];
				n.modrm = pwdata[15:8];
				n.imm = pwdata[23:16];
				n.spBase = pwdata[INSTR_SPBASE];
			end
			else if (paddr == OFF_FLAGS)
				n.flags = pwdata[15:0];
			else if (paddr == OFF_DISP)
				n.disp = pwdata[15:0];
			else if ((paddr[7:5] == OFF_SEG[7:5]) && !paddr[4])
				n.seg[paddr[3:2]] = pwdata[15:0];
			else if (paddr[7:5] == OFF_GPR[7:5])
				n.gpr[paddr[4:2]] = pwdata[15:0];
		end
		// Decode of a new instruction.
		if (launch)
		begin
			n.cnt = clocksFor(r.opcode, pwdata[CTRL_VARIANT]);
			n.busy = 1'b1;
			n.illegal = 1'b0;
			n.half = 1'b0;
			n.popSs = 1'b0;
			if ((r.opcode[7:4] == OP_OUT_IB[7:4]) && (r.opcode[2:1] == OP_OUT_IB[2:1]))
			begin
				n.data = r.gpr[GPR_AX];
				// Bit 3 picks the port register form over the immediate form.
				n.addrOff = r.opcode[3] ? r.gpr[GPR_DX] : {8'h00, r.imm};
				n.st = S_WRITE;
			end
			else if (strOp)
			begin
				// A repeat with a zero count moves nothing and leaves the index alone.
				if (pwdata[CTRL_REP] && (r.gpr[GPR_CX] == 16'h0))
					fin = 1'b1;
				else
				begin
					n.mem.req = 1'b1;
					n.mem.we = 1'b0;
					n.mem.isByte = !r.opcode[0] || pwdata[CTRL_VARIANT];
					n.mem.addr = phys(r.seg[SEG_DS], r.gpr[GPR_SI]);
					n.st = S_READ;
				end
			end
			else if (isPop(r.opcode, r.modrm))
			begin
				// Pops always read the word at the top of the stack first.
				n.mem.req = 1'b1;
				n.mem.we = 1'b0;
				n.mem.isByte = pwdata[CTRL_VARIANT];
				n.mem.addr = phys(r.seg[SEG_SS], r.gpr[GPR_SP]);
				n.st = S_READ;
			end
			else
			begin
				// Includes the code segment pop and other reg fields of 8F.
				n.illegal = 1'b1;
				fin = 1'b1;
			end
		end
		// Sequencer.
		case (r.st)
			S_READ:
			begin
				if (memAck)
				begin
					// Merge the returned byte or word into the holding register.
					if (r.half)
						capt[15:8] = memRdata[7:0];
					else if (split || !word)
						capt = {8'h00, memRdata[7:0]};
					else
						capt = memRdata;
					n.data = capt;
					if (split && !r.half)
					begin
						// Low byte first, then the high byte at the next address.
						n.half = 1'b1;
						n.mem.addr = r.mem.addr + 20'h1;
					end
					else
					begin
						n.half = 1'b0;
						n.mem.req = 1'b0;
						if (strOp)
						begin
							n.addrOff = r.gpr[GPR_DX];
							n.st = S_WRITE;
						end
						else
						begin
							n.gpr[GPR_SP] = newSp;
							n.st = S_WAIT;
							if (r.opcode == OP_POP_M)
							begin
								// The stack based address sees the pointer after its step.
								n.mem.req = 1'b1;
								n.mem.we = 1'b1;
								n.mem.isByte = r.variant;
								n.mem.addr = phys(r.seg[SEG_DS], r.disp + (r.spBase ? newSp : 16'h0));
								n.mem.wdata = r.variant ? {8'h00, capt[7:0]} : capt;
								n.st = S_STORE;
							end
							else if (r.opcode[7:3] == OP_POP_R)
								n.gpr[r.opcode[2:0]] = capt;
							else if (r.opcode == OP_POP_DS)
								n.seg[SEG_DS] = capt;
							else if (r.opcode == OP_POP_ES)
								n.seg[SEG_ES] = capt;
							else
							begin
								n.seg[SEG_SS] = capt;
								n.popSs = 1'b1;
							end
						end
					end
				end
			end
			S_STORE:
			begin
				if (memAck)
				begin
					if (split && !r.half)
					begin
						n.half = 1'b1;
						n.mem.addr = r.mem.addr + 20'h1;
						n.mem.wdata = {8'h00, r.data[15:8]};
					end
					else
					begin
						n.half = 1'b0;
						n.mem.req = 1'b0;
						n.mem.we = 1'b0;
						n.st = S_WAIT;
					end
				end
			end
			S_WRITE:
			begin
				// One I/O write pulse per cycle; a split word takes two cycles back to back.
				n.io.req = 1'b1;
				n.io.isByte = !word || r.variant;
				n.io.addr = r.addrOff + {15'h0, r.half};
				n.io.data = (word && !r.variant) ? r.data : {8'h00, r.half ? r.data[15:8] : r.data[7:0]};
				if (split && !r.half)
					n.half = 1'b1;
				else
				begin
					n.half = 1'b0;
					n.st = S_WAIT;
					if (strOp)
					begin
						n.gpr[GPR_SI] = siStep(r.gpr[GPR_SI], word, r.flags[DF_BIT]);
						if (r.repeat_prefix)
							n.gpr[GPR_CX] = r.gpr[GPR_CX] - 16'h1;
					end
				end
			end
			S_WAIT:
			begin
				// Hold until the documented clock count has passed.
				if (r.cnt <= CLK_MIN)
				begin
					if (strOp && r.repeat_prefix && (r.gpr[GPR_CX] != 16'h0))
					begin
						// Next element of a block output.
						n.cnt = CLK_STR;
						n.mem.req = 1'b1;
						n.mem.we = 1'b0;
						n.mem.isByte = !word || r.variant;
						n.mem.addr = phys(r.seg[SEG_DS], r.gpr[GPR_SI]);
						n.st = S_READ;
					end
					else
						fin = 1'b1;
				end
			end
			default:
			begin
				// Idle: nothing to sequence.
				n.half = 1'b0;
			end
		endcase
		// Completion; the flags word is never touched here.
		if (fin)
		begin
			n.st = S_IDLE;
			n.busy = 1'b0;
			n.done = 1'b1;
			n.cnt = 6'h00;
			// Set after a stack segment pop, cleared when the next instruction completes.
			n.inhibit = n.popSs;
		end
	end

	// State register.
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			r <= '0;
			r.st <= S_IDLE;
			r.pcbIo <= PCB_IO_RST;
		end
		else
			r <= n;
	end

	// Immediate forms put a zero high byte on the port address.
	a_imm_port_zero: assert property (@(posedge mclk) disable iff (!rstn)
		$rose(io.req) && ((r.opcode == OP_OUT_IB) || (r.opcode == OP_OUT_IW)) |-> io.addr == {8'h00, r.imm})
		else $error("immediate port not zero extended");
	// Port register forms and string output address the port register.
	a_dx_port_addr: assert property (@(posedge mclk) disable iff (!rstn)
		$rose(io.req) && (r.opcode[3:0] != OP_OUT_IB[3:0]) && (r.opcode[3:0] != OP_OUT_IW[3:0])
		|-> io.addr == r.gpr[GPR_DX])
		else $error("port register not used as port");
	// A byte output is one byte cycle alone.
	a_byte_out_one: assert property (@(posedge mclk) disable iff (!rstn)
		$rose(io.req) && ((r.opcode == OP_OUT_IB) || (r.opcode == OP_OUT_DB)) |-> io.isByte ##1 !io.req)
		else $error("byte output not a single byte cycle");
	// On the byte bus variant a word output is two adjacent byte cycles.
	a_split_word_io: assert property (@(posedge mclk) disable iff (!rstn)
		$rose(io.req) && r.variant && ((r.opcode == OP_OUT_IW) || (r.opcode == OP_OUT_DW))
		|-> io.isByte ##1 (io.req && (io.addr == $past(io.addr) + 16'h1)) ##1 !io.req)
		else $error("word output not split in two bytes");
	// An immediate byte output takes nine clocks.
	a_out_imm_time: assert property (@(posedge mclk) disable iff (!rstn)
		launch && (r.opcode == OP_OUT_IB) |-> ##9 r.busy ##1 !r.busy)
		else $error("immediate byte output length wrong");
	// A port register word output on the byte bus variant takes eleven clocks.
	a_out_dx_time: assert property (@(posedge mclk) disable iff (!rstn)
		launch && (r.opcode == OP_OUT_DW) && pwdata[CTRL_VARIANT] |-> ##11 r.busy ##1 !r.busy)
		else $error("port register word output length wrong");
	// A pop steps the stack pointer by two unless it loads the pointer itself.
	a_pop_sp_step: assert property (@(posedge mclk) disable iff (!rstn)
		(r.st == S_READ) && memAck && !strOp && !(split && !r.half) && (r.opcode != 8'h5c)
		|=> r.gpr[GPR_SP] == $past(r.gpr[GPR_SP]) + STACK_STEP)
		else $error("stack pointer not stepped by two");
	// Each string element steps the source index by its size and direction.
	a_str_si_step: assert property (@(posedge mclk) disable iff (!rstn)
		(r.st == S_WRITE) && strOp && !(split && !r.half)
		|=> r.gpr[GPR_SI] == siStep($past(r.gpr[GPR_SI]), $past(word), $past(r.flags[DF_BIT])))
		else $error("source index step wrong");
	// Completion of a stack segment pop raises the interrupt block.
	a_ss_inhibit: assert property (@(posedge mclk) disable iff (!rstn)
		fin && r.popSs && (r.st == S_WAIT) |=> intBlock ##1 intBlock)
		else $error("interrupt block missing after stack segment pop");
	// The flags word changes only through its own register write.
	a_flags_kept: assert property (@(posedge mclk) disable iff (!rstn)
		!(wr && (paddr == OFF_FLAGS)) |=> $stable(r.flags))
		else $error("flags changed by execution");
	// A code segment pop is refused at once.
	a_no_pop_cs: assert property (@(posedge mclk) disable iff (!rstn)
		launch && (r.opcode == 8'h0f) |=> r.illegal && !r.busy && !mem.req)
		else $error("code segment pop not refused");
	// A repeated string output with zero count ends at once and moves nothing.
	a_rep_zero: assert property (@(posedge mclk) disable iff (!rstn)
		launch && strOp && pwdata[CTRL_REP] && (r.gpr[GPR_CX] == 16'h0)
		|=> !r.busy && !mem.req && (r.gpr[GPR_SI] == $past(r.gpr[GPR_SI])))
		else $error("zero count block output did work");
endmodule : port_output_and_stack_pop_exec

// *** test_port_output_and_stack_pop_exec.sv ***
// Self-checking bench: APB tasks run each instruction and compare ports, registers and memory.
// Assumes the package register map and the memory model in pop_out_mem.
`timescale 1ns/1ns
module test_port_output_and_stack_pop_exec
	import pop_out_pkg::*;
;
	logic        mclk = 1'b0;
	logic        rstn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready, pslverr, memAck, intBlock, pcbInIoSpace;
	logic        slow = 1'b0;  // Adds memory wait states when high.
	logic [15:0] memRdata;
	io_wr_t      io;
	mem_req_t    mem;
	io_wr_t      ioQ[$];       // Every I/O write cycle seen, in order.
	int          mismatches = 0;
	int          totalChecks = 0;

	port_output_and_stack_pop_exec u_dut (.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.io(io), .mem(mem), .memRdata(memRdata), .memAck(memAck), .intBlock(intBlock),
		.pcbInIoSpace(pcbInIoSpace));
	pop_out_mem u_mem (.mclk(mclk), .rstn(rstn), .mem(mem), .slow(slow), .memRdata(memRdata), .memAck(memAck));

	always #20 mclk = ~mclk;

	// Record I/O cycles; a pulse lasts one cycle, so each edge with req high is one cycle.
	always @(posedge mclk)
		if (io.req === 1'b1)
			ioQ.push_back(io);

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", totalChecks, mismatches);
		if (mismatches == 0 && totalChecks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : give_verdict

	task automatic check(input logic [39:0] seen, input logic [39:0] exp);
		totalChecks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask : check

	// One APB transfer; the request stands until pready is sampled high.
	task automatic apbXfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		int k;
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge mclk);
		penable <= 1'b1;
		k = 0;
		@(posedge mclk);
		while (pready !== 1'b1 && k < 50)
		begin
			k++;
			@(posedge mclk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 50)
			check(1'b0, 1'b1);
	endtask : apbXfer

	task automatic apbWr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] rd;
		logic        e;
		apbXfer(1'b1, a, d, rd, e);
	endtask : apbWr

	task automatic apbRd(input logic [7:0] a, output logic [31:0] rd);
		logic e;
		apbXfer(1'b0, a, 32'h0, rd, e);
	endtask : apbRd

	task automatic chkReg(input logic [7:0] a, input logic [15:0] exp);
		logic [31:0] rd;
		apbRd(a, rd);
		check(rd, {16'h0000, exp});
	endtask : chkReg

	function automatic logic [7:0] gpr(input int i);
		return OFF_GPR + 8'(i * 4);
	endfunction : gpr

	function automatic logic [7:0] seg(input int i);
		return OFF_SEG + 8'(i * 4);
	endfunction : seg

	task automatic putW(input logic [19:0] a, input logic [15:0] w);
		u_mem.memB[a] = w[7:0];
		u_mem.memB[a + 20'h1] = w[15:8];
	endtask : putW

	task automatic expIo(input logic b, input logic [15:0] a, input logic [15:0] d);
		io_wr_t got;
		got = (ioQ.size() > 0) ? ioQ.pop_front() : '0;
		check(got, {1'b1, b, a, d});
	endtask : expIo

	// Launch one instruction; with n above zero, busy must still stand near the end and be gone
	// at the first poll after it, which pins the clock count to a window of a few cycles.
	task automatic runOp(input logic [7:0] op, input logic [7:0] modrm, input logic [7:0] imm,
		input logic spb, input logic vr, input logic rp, input int n);
		logic [31:0] rd;
		int          k;
		apbWr(OFF_STATUS, 32'h2);
		apbWr(OFF_INSTR, {7'h00, spb, imm, modrm, op});
		apbWr(OFF_CTRL, {29'h0, rp, vr, 1'b1});
		if (n > 0)
		begin
			repeat (n - 4) @(posedge mclk);
			apbRd(OFF_STATUS, rd);
			check(rd[0], 1'b1);
		end
		k = 0;
		apbRd(OFF_STATUS, rd);
		while (rd[0] !== 1'b0 && k < 300)
		begin
			k++;
			apbRd(OFF_STATUS, rd);
		end
		if (n > 0)
			check(40'(k), 40'h0);
		check(rd[ST_DONE], 1'b1);
	endtask : runOp

	initial
	begin
		logic [31:0] rd;
		logic        e, w;
		logic [7:0]  op;
		logic [15:0] port, val, sp, ds;
		logic [19:0] a;
		logic [7:0]  popOps [5];
		int          n;
		popOps = '{OP_POP_M, {OP_POP_R, 3'd3}, OP_POP_ES, OP_POP_DS, OP_POP_SS};
		repeat (3) @(posedge mclk);
		rstn <= 1'b1;
		check(pcbInIoSpace, 1'b1);
		apbXfer(1'b0, 8'h80, 32'h0, rd, e);
		check({e, rd}, {1'b1, 32'h0});
		apbWr(OFF_CTRL, 32'h8);
		chkReg(OFF_CTRL, 16'h0008);
		check(pcbInIoSpace, 1'b0);
		apbWr(OFF_CTRL, 32'h0);
		chkReg(OFF_CTRL, 16'h0000);
		check(pcbInIoSpace, 1'b1);
		$display("test reset_and_map done");
		apbWr(gpr(GPR_AX), 32'h1234);
		apbWr(gpr(GPR_DX), 32'hfffe);
		for (int v = 0; v < 2; v++)
			for (int i = 0; i < 4; i++)
			begin
				op = {4'he, 1'(i >> 1), 2'b11, 1'(i)};
				w = op[0];
				port = op[3] ? 16'hfffe : 16'h00a5;
				n = op[3] ? ((w && v) ? CLK_OUT_DW2 : CLK_OUT_D) : ((w && v) ? CLK_OUT_IW2 : CLK_OUT_I);
				runOp(op, 8'h00, 8'ha5, 1'b0, 1'(v), 1'b0, n);
				if (!w)
					expIo(1'b1, port, 16'h0034);
				else if (v == 0)
					expIo(1'b0, port, 16'h1234);
				else
				begin
					expIo(1'b1, port, 16'h0034);
					expIo(1'b1, port + 16'h1, 16'h0012);
				end
				check(40'(ioQ.size()), 40'h0);
			end
		$display("test port_output done");
		ds = 16'h1000;
		apbWr(seg(SEG_DS), 32'h1000);
		apbWr(gpr(GPR_SI), 32'h0100);
		apbWr(gpr(GPR_CX), 32'h3);
		apbWr(OFF_FLAGS, 32'h08c1);
		for (int i = 0; i < 3; i++)
			putW(20'h10100 + 20'(2 * i), 16'hc0d0 + 16'(i));
		slow <= 1'b1;
		runOp(OP_STR_W, 8'h00, 8'h00, 1'b0, 1'b0, 1'b1, 0);
		for (int i = 0; i < 3; i++)
			expIo(1'b0, 16'hfffe, 16'hc0d0 + 16'(i));
		chkReg(gpr(GPR_SI), 16'h0106);
		chkReg(gpr(GPR_CX), 16'h0000);
		slow <= 1'b0;
		apbWr(OFF_FLAGS, 32'h04c1);
		apbWr(gpr(GPR_SI), 32'h0200);
		u_mem.memB[20'h10200] = 8'h5a;
		runOp(OP_STR_B, 8'h00, 8'h00, 1'b0, 1'b0, 1'b0, CLK_STR);
		expIo(1'b1, 16'hfffe, 16'h005a);
		chkReg(gpr(GPR_SI), 16'h01ff);
		chkReg(OFF_FLAGS, 16'h04c1);
		runOp(OP_STR_B, 8'h00, 8'h00, 1'b0, 1'b0, 1'b1, 0);
		chkReg(gpr(GPR_SI), 16'h01ff);
		check(40'(ioQ.size()), 40'h0);
		$display("test string_output done");
		sp = 16'h0010;
		apbWr(seg(SEG_SS), 32'h2000);
		apbWr(gpr(GPR_SP), 32'h0010);
		apbWr(OFF_DISP, 32'h0004);
		for (int v = 0; v < 2; v++)
			for (int i = 0; i < 5; i++)
			begin
				op = popOps[i];
				val = (op == OP_POP_SS) ? 16'h2000 : 16'ha000 + 16'(v * 16 + i);
				putW(20'h20000 + 20'(sp), val);
				n = (op == OP_POP_M) ? (v ? CLK_POP_M2 : CLK_POP_M) : (op[7:3] == OP_POP_R) ?
					(v ? CLK_POP_R2 : CLK_POP_R) : (v ? CLK_POP_S2 : CLK_POP_S);
				runOp(op, 8'h00, 8'h00, op == OP_POP_M, 1'(v), 1'b0, n);
				sp = sp + 16'h2;
				chkReg(gpr(GPR_SP), sp);
				a = {ds, 4'h0} + 20'(16'h0004 + sp);
				if (op == OP_POP_M)
					check({u_mem.memB[a + 20'h1], u_mem.memB[a]}, val);
				else if (op == OP_POP_ES)
					chkReg(seg(SEG_ES), val);
				else if (op == OP_POP_DS)
					chkReg(seg(SEG_DS), val);
				else if (op == OP_POP_SS)
					chkReg(seg(SEG_SS), val);
				else
					chkReg(gpr(3), val);
				if (op == OP_POP_DS)
					ds = val;
				check(intBlock, op == OP_POP_SS);
			end
		runOp(OP_POP_M, 8'h08, 8'h00, 1'b0, 1'b0, 1'b0, 0);
		apbRd(OFF_STATUS, rd);
		check(rd[2], 1'b1);
		runOp(8'h0f, 8'h00, 8'h00, 1'b0, 1'b0, 1'b0, 0);
		apbRd(OFF_STATUS, rd);
		check(rd[2], 1'b1);
		chkReg(gpr(GPR_SP), sp);
		check(40'(ioQ.size()), 40'h0);
		$display("test stack_pop done");
		give_verdict();
	end

	// Cut a hang short well past the expected run length.
	initial
	begin
		#2000000;
		mismatches++;
		give_verdict();
	end
endmodule : test_port_output_and_stack_pop_exec
